/* core/reset_state_control.sv */
// reset state control: merges reset sources, sequences hold, stabilization
// wait and vector fetch, and owns the reset-initialised cpu registers
// assumes an apb master on pclk and asynchronous reset source pins
`timescale 1ns/10ps
`default_nettype none
`include "rsc_regs.svh"

module reset_state_control #(
    parameter int MIN_LOW_CYC = `EXT_RST_MIN_CYC
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire rsc_pkg::apb_req_s apb_req,
    output var  rsc_pkg::apb_rsp_s apb_rsp,
    input  wire logic              reset_pin_n,
    input  wire logic              wdt_overflow,
    input  wire logic              poc_detect,
    input  wire logic              lvi_detect,
    input  wire logic              standby_mode,
    input  wire logic [15:0]       rom_vector,
    output var  rsc_pkg::ctl_s     ctl,
    output var  logic [15:0]       pc
);
    import rsc_pkg::*;

    state_s s_q;
    state_s s_d;

    ////////////////////////////////////////////////////////////////////////
    // register read mux
    function automatic logic [32:0] reg_read(input state_s s, input logic [7:0] a);
        logic [32:0] r;
        r = 33'h0_0000_0000;
        case (a)
            `OFS_PSW:     r[7:0]  = s.program_status_word;
            `OFS_STACK:   r[15:0] = s.stack_pointer;
            `OFS_LATCH:   r[23:0] = s.port_output_latches;
            `OFS_DIR:     r[23:0] = s.port_direction_regs;
            `OFS_PU3:     r[7:0]  = s.pullup_option_port3;
            `OFS_PULLUP_OPTION_PORT_TWELVE:    r[7:0]  = s.pullup_option_port_twelve;
            `OFS_MEMSIZE: r[7:0]  = s.memory_size_select;
            `OFS_CTRL:    r[2:0]  = s.clk_ctrl;
            `OFS_STATUS: begin
                r[3:0]                         = s.src_seen;
                r[`ST_SHORT]                   = s.short_flag;
                r[`ST_PHASE_LO+1:`ST_PHASE_LO] = s.phase;
                r[`ST_KEEP]                    = s.keep;
            end
            `OFS_WAIT:    r[15:0] = s.wait_len;
            `OFS_PC:      r[15:0] = s.pc;
            default:      r[32]   = 1'b1; // unmapped: error flag
        endcase
        return r;
    endfunction : reg_read

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        logic [3:0]  req;
        logic        any_req;
        logic        access;
        logic        wr;
        logic [32:0] rd;
        logic        held;
        logic        done;
        req     = s_q.src_s;
        any_req = |req;
        access  = apb_req.psel && apb_req.penable && !s_q.rsp.pready;
        // writes land at the edge where the master sees pready
        done    = apb_req.psel && apb_req.penable && s_q.rsp.pready;
        wr      = done && apb_req.pwrite && (s_q.phase == PH_RUN);
        rd      = reg_read(s_q, apb_req.paddr);
        held    = 1'b0;

        s_d = s_q;
        // two-stage synchronisers for the source pins
        s_d.src_m = {lvi_detect, poc_detect, wdt_overflow, ~reset_pin_n};
        s_d.src_s = s_q.src_m;
        s_d.rsp.pready  = 1'b0;
        s_d.rsp.pslverr = 1'b0;

        // sticky source flags, set beats write-one-to-clear
        s_d.src_seen = s_q.src_seen | req;
        if (done && apb_req.pwrite && apb_req.paddr == `OFS_STATUS) begin
            s_d.src_seen   = (s_q.src_seen & ~apb_req.pwdata[3:0]) | req;
            s_d.short_flag = s_q.short_flag & ~apb_req.pwdata[`ST_SHORT];
        end

        // pin pulse width check
        if (req[`SRC_PIN]) begin
            if (s_q.low_cnt != 16'hffff) begin
                s_d.low_cnt = s_q.low_cnt + 16'h0001;
            end
        end else begin
            if (s_q.low_cnt != 16'h0000 && s_q.low_cnt < 16'(MIN_LOW_CYC)) begin
                s_d.short_flag = 1'b1;
            end
            s_d.low_cnt = 16'h0000;
        end

        // apb register writes, only while the cpu runs
        if (wr) begin
            case (apb_req.paddr)
                `OFS_PSW:     s_d.program_status_word       = apb_req.pwdata[7:0];
                `OFS_STACK:   s_d.stack_pointer             = apb_req.pwdata[15:0];
                `OFS_LATCH:   s_d.port_output_latches       = apb_req.pwdata[23:0];
                `OFS_DIR:     s_d.port_direction_regs       = apb_req.pwdata[23:0];
                `OFS_PU3:     s_d.pullup_option_port3       = apb_req.pwdata[7:0];
                `OFS_PULLUP_OPTION_PORT_TWELVE:    s_d.pullup_option_port_twelve = apb_req.pwdata[7:0];
                `OFS_MEMSIZE: s_d.memory_size_select        = apb_req.pwdata[7:0];
                `OFS_CTRL:    s_d.clk_ctrl                  = apb_req.pwdata[2:0];
                `OFS_WAIT:    s_d.wait_len                  = apb_req.pwdata[15:0];
                default: ;
            endcase
        end
        if (access) begin
            s_d.rsp.pready  = 1'b1;
            s_d.rsp.pslverr = rd[32];
            s_d.rsp.prdata  = apb_req.pwrite ? 32'h0000_0000 : rd[31:0];
        end

        // reset sequencer
        s_d.ctl.wdt_clear = 1'b0;
        s_d.ctl.pc_load   = 1'b0;
        case (s_q.phase)
            PH_RUN: begin
                if (any_req) begin
                    s_d.phase     = PH_HOLD;
                    s_d.keep      = standby_mode;
                    s_d.lvi_src   = req[`SRC_LVI];
                    s_d.ctl.wdt_clear = req[`SRC_WDT];
                end
            end
            PH_HOLD: begin
                // reset values; stack pointer and memory left alone
                s_d.program_status_word       = `RST_PSW;
                s_d.port_output_latches       = `RST_LATCH;
                s_d.port_direction_regs       = `RST_DIR;
                s_d.pullup_option_port3       = `RST_PU3;
                s_d.pullup_option_port_twelve = `RST_PULLUP_OPTION_PORT_TWELVE;
                s_d.memory_size_select        = `RST_MEMSIZE;
                s_d.clk_ctrl                  = 3'b000;
                s_d.lvi_src                   = req[`SRC_LVI];
                s_d.ctl.wdt_clear             = req[`SRC_WDT];
                if (!any_req) begin
                    s_d.phase    = PH_STAB;
                    s_d.wait_cnt = 16'h0000;
                end
            end
            PH_STAB: begin
                if (any_req) begin
                    s_d.phase   = PH_HOLD;
                    s_d.lvi_src = req[`SRC_LVI];
                end else if (s_q.wait_cnt + 16'h0001 >= s_q.wait_len) begin
                    s_d.phase = PH_VECT;
                end else begin
                    s_d.wait_cnt = s_q.wait_cnt + 16'h0001;
                end
            end
            PH_VECT: begin
                s_d.pc          = rom_vector;
                s_d.ctl.pc_load = 1'b1;
                s_d.phase       = PH_RUN;
            end
            default: s_d.phase = PH_HOLD;
        endcase

        // control outputs follow the next phase
        held = (s_d.phase == PH_HOLD);
        s_d.ctl.internal_reset   = held;
        s_d.ctl.cpu_clk_en       = (s_d.phase == PH_RUN);
        s_d.ctl.cpu_clk_internal = !s_d.clk_ctrl[`CTRL_XTAL_SEL];
        s_d.ctl.xtal_osc_en      = !held && s_d.clk_ctrl[`CTRL_XTAL_EN];
        s_d.ctl.xtal_pins_input  = held || !s_d.clk_ctrl[`CTRL_XTAL_EN];
        s_d.ctl.ext_clk_valid    = !held && s_d.clk_ctrl[`CTRL_EXT_EN];
        s_d.ctl.ram_access_en    = !held;
        s_d.ctl.ram_keep         = 1'b1;
        s_d.ctl.poc_en           = 1'b1;
        s_d.ctl.lvi_en           = !held || s_d.lvi_src;
        s_d.ctl.pins_hiz         = held || (s_d.phase == PH_STAB);
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q                           <= '0;
            s_q.phase                     <= PH_HOLD;
            s_q.wait_len                  <= `RST_WAIT;
            s_q.program_status_word       <= `RST_PSW;
            s_q.port_direction_regs       <= `RST_DIR;
            s_q.pullup_option_port_twelve <= `RST_PULLUP_OPTION_PORT_TWELVE;
            s_q.memory_size_select        <= `RST_MEMSIZE;
            s_q.ctl.internal_reset        <= 1'b1;
            s_q.ctl.xtal_pins_input       <= 1'b1;
            s_q.ctl.cpu_clk_internal      <= 1'b1;
            s_q.ctl.ram_keep              <= 1'b1;
            s_q.ctl.poc_en                <= 1'b1;
            s_q.ctl.pins_hiz              <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign apb_rsp = s_q.rsp;
    assign ctl     = s_q.ctl;
    assign pc      = s_q.pc;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_CPU_GATED: assert property (s_q.phase != PH_RUN |-> !ctl.cpu_clk_en)
        else $error("cpu clock running outside run phase");
    AST_XTAL_STOP: assert property (s_q.phase == PH_HOLD |-> !ctl.xtal_osc_en && ctl.xtal_pins_input)
        else $error("crystal active during reset");
    AST_EXT_CLK: assert property (s_q.phase == PH_HOLD |-> !ctl.ext_clk_valid)
        else $error("external clock valid during reset");
    AST_RAM_HALT: assert property (s_q.phase == PH_HOLD |-> !ctl.ram_access_en && ctl.ram_keep)
        else $error("ram accessible during reset");
    AST_DETECTORS: assert property (ctl.poc_en && (s_q.phase != PH_HOLD || s_q.lvi_src || !ctl.lvi_en))
        else $error("detector enables wrong during reset");
    AST_WDT_CLEAR: assert property (s_q.phase == PH_RUN && s_q.src_s[`SRC_WDT] |=> ctl.wdt_clear)
        else $error("watchdog reset did not clear watchdog");
    AST_VECTOR: assert property (s_q.phase == PH_VECT |=> ctl.pc_load && pc == $past(rom_vector) ##1 !ctl.pc_load)
        else $error("reset vector not loaded");
    AST_INIT_REGS: assert property (s_q.phase == PH_HOLD ##1 s_q.phase == PH_HOLD |->
            s_q.program_status_word == `RST_PSW && s_q.port_direction_regs == `RST_DIR
            && s_q.port_output_latches == `RST_LATCH && s_q.memory_size_select == `RST_MEMSIZE
            && s_q.pullup_option_port_twelve == `RST_PULLUP_OPTION_PORT_TWELVE)
        else $error("register reset values wrong");
    AST_STACK_KEPT: assert property (s_q.phase != PH_RUN |=> $stable(s_q.stack_pointer))
        else $error("stack pointer disturbed by reset");
    AST_HIZ: assert property (s_q.phase == PH_HOLD || s_q.phase == PH_STAB |-> ctl.pins_hiz)
        else $error("pins driven during reset or wait");
    AST_RESET_OR: assert property (s_q.phase == PH_RUN && |s_q.src_s |=> s_q.phase == PH_HOLD
            && ctl.internal_reset)
        else $error("reset source not merged");
    AST_START_INTERNAL: assert property ($rose(ctl.pc_load) |-> ctl.cpu_clk_internal && ctl.cpu_clk_en)
        else $error("execution not started on internal clock");

endmodule : reset_state_control
`default_nettype wire

/* core/rsc_pkg.sv */
// types for the reset state control block
// assumes rsc_regs.svh supplies all numbers
`include "rsc_regs.svh"
package rsc_pkg;
    typedef enum logic [1:0] {
        PH_RUN  = 2'b00,
        PH_HOLD = 2'b01,
        PH_STAB = 2'b10,
        PH_VECT = 2'b11
    } phase_e;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;

    typedef struct packed {
        logic cpu_clk_en;
        logic cpu_clk_internal;
        logic xtal_osc_en;
        logic xtal_pins_input;
        logic ext_clk_valid;
        logic ram_access_en;
        logic ram_keep;
        logic poc_en;
        logic lvi_en;
        logic wdt_clear;
        logic pins_hiz;
        logic pc_load;
        logic internal_reset;
    } ctl_s;

    typedef struct packed {
        logic [3:0]  src_m;
        logic [3:0]  src_s;
        logic [3:0]  src_seen;
        logic        short_flag;
        logic        lvi_src;
        logic        keep;
        phase_e      phase;
        logic [15:0] wait_cnt;
        logic [15:0] wait_len;
        logic [15:0] low_cnt;
        logic [15:0] pc;
        logic [15:0] stack_pointer;
        logic [7:0]  program_status_word;
        logic [23:0] port_output_latches;
        logic [23:0] port_direction_regs;
        logic [7:0]  pullup_option_port3;
        logic [7:0]  pullup_option_port_twelve;
        logic [7:0]  memory_size_select;
        logic [2:0]  clk_ctrl;
        apb_rsp_s    rsp;
        ctl_s        ctl;
    } state_s;
endpackage : rsc_pkg

/* core/rsc_regs.svh */
// constants for the reset state control block: offsets, reset values, timing
// assumes a 100 MHz pclk and a 32-bit apb with byte addresses
`ifndef RSC_REGS_SVH
`define RSC_REGS_SVH

// register byte offsets
`define OFS_PSW        8'h00
`define OFS_STACK      8'h04
`define OFS_LATCH      8'h08
`define OFS_DIR        8'h0c
`define OFS_PU3        8'h10
`define OFS_PULLUP_OPTION_PORT_TWELVE       8'h14
`define OFS_MEMSIZE    8'h18
`define OFS_CTRL       8'h1c
`define OFS_STATUS     8'h20
`define OFS_WAIT       8'h24
`define OFS_PC         8'h28

// reset values
`define RST_PSW        8'h02
`define RST_LATCH      24'h00_0000
`define RST_DIR        24'hff_ffff
`define RST_PU3        8'h00
`define RST_PULLUP_OPTION_PORT_TWELVE       8'h20
`define RST_MEMSIZE    8'hcf
`define RST_WAIT       16'h0010

// field positions
`define CTRL_XTAL_SEL  0
`define CTRL_XTAL_EN   1
`define CTRL_EXT_EN    2
`define ST_SHORT       4
`define ST_PHASE_LO    5
`define ST_KEEP        7
`define SRC_PIN        0
`define SRC_WDT        1
`define SRC_POC        2
`define SRC_LVI        3

// timing: least external reset pulse
`define CLK_PERIOD_NS  10
`define EXT_RST_MIN_NS 10000
`define EXT_RST_MIN_CYC ((`EXT_RST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* sim/rst_src_model.sv */
// reset source model: pin, watchdog, power-on clear and low-voltage requests
// assumes the bench calls pulse from its main sequence, one request at a time
`timescale 1ns/10ps
`default_nettype none

module rst_src_model #(
    parameter int MIN_LOW = 20
) (
    input  wire logic pclk,
    output var  logic reset_pin_n,
    output var  logic wdt_overflow,
    output var  logic poc_detect,
    output var  logic lvi_detect
);
    ////////////////////////////////////////////////////////////////////////
    // all requests idle at time zero
    initial begin
        reset_pin_n  = 1'b1;
        wdt_overflow = 1'b0;
        poc_detect   = 1'b0;
        lvi_detect   = 1'b0;
    end

    // raise or drop one request line just after an edge
    task automatic drive(input int src, input logic on);
        case (src)
            0: reset_pin_n <= ~on;
            1: wdt_overflow <= on;
            2: poc_detect <= on;
            default: lvi_detect <= on;
        endcase
    endtask : drive

    // one request for cyc cycles; the pin is never shorter than the minimum
    task automatic pulse(input int src, input int cyc);
        int n;
        n = (src == 0 && cyc < MIN_LOW) ? MIN_LOW : cyc;
        @(posedge pclk);
        drive(src, 1'b1);
        repeat (n) @(posedge pclk);
        drive(src, 1'b0);
    endtask : pulse
endmodule : rst_src_model

`default_nettype wire

/* sim/tb.sv */
// testbench for the reset state control block with a register model
// assumes rsc_pkg is compiled first and the reset source model beside it
`timescale 1ns/10ps
`default_nettype none

module tb;
    import rsc_pkg::*;
    localparam int MINL = 20;
    logic        pclk;
    logic        presetn;
    logic        standby_mode;
    logic [15:0] rom_vector;
    logic [15:0] pc;
    apb_req_s    req;
    apb_rsp_s    rsp;
    ctl_s        ctl;
    logic        rpin_n;
    logic        wdt;
    logic        power_on_clear_detector;
    logic        low_voltage_detector;
    logic        err;
    logic        wc;
    logic [31:0] rd;
    int          mismatches;
    int          n_compared;
    logic [31:0] mdl [9];
    logic [31:0] msk [9] = '{32'hff, 32'hffff, 32'hff_ffff, 32'hff_ffff, 32'hff, 32'hff, 32'hff, 32'h7, 32'h0};

    reset_state_control #(.MIN_LOW_CYC(MINL)) reset_state_control_i (
        .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .reset_pin_n(rpin_n),
        .wdt_overflow(wdt), .poc_detect(power_on_clear_detector), .lvi_detect(low_voltage_detector), .standby_mode(standby_mode),
        .rom_vector(rom_vector), .ctl(ctl), .pc(pc));

    rst_src_model #(.MIN_LOW(MINL)) rst_src_model_i (
        .pclk(pclk), .reset_pin_n(rpin_n), .wdt_overflow(wdt), .poc_detect(power_on_clear_detector), .lvi_detect(low_voltage_detector));

    // free running 100 mhz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic results();
        if (mismatches == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer, held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            mismatches++;
            $display("[ERR] %0t no pready", $time);
            results();
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask : apb

    // model write: taken only while the cpu runs
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        if (ctl.cpu_clk_en === 1'b1) begin
            mdl[a[5:2]] = d & msk[a[5:2]];
        end
    endtask : wr

    task automatic rdc(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
        chk(rd, mdl[a[5:2]]);
        chk(err, 1'b0);
    endtask : rdc

    // values every internal reset restores; stack pointer left alone
    function automatic void mdl_reset();
        mdl[0] = 32'h02;
        mdl[2] = 32'h0;
        mdl[3] = 32'hff_ffff;
        mdl[4] = 32'h00;
        mdl[5] = 32'h20;
        mdl[6] = 32'hcf;
        mdl[7] = 32'h0;
    endfunction : mdl_reset

    // wait for hold (internal reset) or run, collecting watchdog clears
    task automatic wait_for(input logic hold);
        int n;
        n = 0;
        do begin
            @(negedge pclk);
            wc |= ctl.wdt_clear;
            n++;
        end while ((hold ? ctl.internal_reset : ctl.cpu_clk_en) !== 1'b1 && n < 3000);
        if (n >= 3000) begin
            mismatches++;
            $display("[ERR] %0t phase wait expired", $time);
            results();
        end
    endtask : wait_for

    ////////////////////////////////////////////////////////////////////////
    // main sequence: power-up, memory size codes, one reset per source
    initial begin
        void'($urandom(24546));
        presetn = 1'b0;
        standby_mode = 1'b0;
        rom_vector = 16'h0;
        req = '0;
        mismatches = 0;
        n_compared = 0;
        wc = 1'b0;
        mdl_reset();
        mdl[1] = 32'h0;
        mdl[8] = 32'h0;
        rom_vector = 16'($urandom);
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        wait_for(1'b0);
        chk(pc, rom_vector);
        for (int a = 0; a < 8; a++) rdc(8'(a * 4));
        apb(1'b0, 8'h30, 32'h0);
        chk({err, rd[30:0]}, 32'h8000_0000);
        foreach (msk[i]) if (i < 3) begin
            wr(8'h18, i == 0 ? 32'h41 : i == 1 ? 32'h42 : 32'h04);
            rdc(8'h18);
        end
        for (int s = 0; s < 4; s++) begin
            for (int a = 0; a < 8; a++) wr(8'(a * 4), $urandom);
            @(negedge pclk);
            chk({ctl.ext_clk_valid, ctl.xtal_osc_en, ~ctl.cpu_clk_internal}, mdl[7]);
            @(posedge pclk);
            rom_vector <= 16'($urandom);
            standby_mode <= (s == 3);
            wc = 1'b0;
            fork
                rst_src_model_i.pulse(s, 5 + $urandom_range(0, 30));
                begin
                    wait_for(1'b1);
                    chk({ctl.cpu_clk_en, ctl.xtal_osc_en, ctl.xtal_pins_input, ctl.ext_clk_valid, ctl.ram_access_en,
                         ctl.ram_keep, ctl.poc_en, ctl.lvi_en, ctl.pins_hiz}, {7'b0010011, s == 3, 1'b1});
                end
            join
            wait_for(1'b0);
            chk(wc, s == 1);
            chk(pc, rom_vector);
            chk({ctl.pins_hiz, ctl.cpu_clk_internal}, 2'b01);
            mdl_reset();
            for (int a = 0; a < 8; a++) rdc(8'(a * 4));
            apb(1'b0, 8'h20, 32'h0);
            chk({rd[7], rd[s]}, {s == 3, 1'b1});
            wr(8'h20, 32'hff);
        end
        results();
    end
endmodule : tb

`default_nettype wire
